// ---- slsfp_pkg.sv ----
package slsfp_pkg;

   // ----------------------------------------------------------------
   // link controller states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SLSFP_ACQ  = 2'b00,   // frequency acquisition, first training fill
      SLSFP_WAIT = 2'b01,   // local lock, waiting for peer
      SLSFP_SEND = 2'b10    // both ends ready, data enabled
   } slsfp_state_t;

   // ----------------------------------------------------------------
   // frame kinds on the decoder side and the encoder side
   // ----------------------------------------------------------------
   localparam logic [1:0] SLSFP_KIND_FILL0 = 2'h0;
   localparam logic [1:0] SLSFP_KIND_FILL1 = 2'h1;
   localparam logic [1:0] SLSFP_KIND_DATA  = 2'h2;
   localparam logic [1:0] SLSFP_KIND_CTRL  = 2'h3;

   // ----------------------------------------------------------------
   // widths and flag positions
   // ----------------------------------------------------------------
   localparam int SLSFP_DW          = 20;
   localparam int SLSFP_WW          = 21;
   localparam int SLSFP_FLAG_POS_N  = 16;   // flag as data, narrow frame
   localparam int SLSFP_FLAG_POS_W  = 20;   // flag as data, wide frame
   localparam logic [20:0] SLSFP_MASK_N = 21'h00_FFFF;
   localparam logic [20:0] SLSFP_MASK_W = 21'h0F_FFFF;

   // ----------------------------------------------------------------
   // counts, in frames or core clock cycles
   // ----------------------------------------------------------------
   localparam logic [1:0] SLSFP_AGREE       = 2'h2;      // frames that must agree
   localparam logic [1:0] SLSFP_ERR_LIMIT   = 2'h2;      // consecutive errors to drop
   localparam logic [7:0] SLSFP_QUIET       = 8'h80;     // 128 clean frames
   localparam logic [3:0] SLSFP_TX_LOCK_EDG = 4'h4;      // rising strobe edges counted before the locking one
   localparam logic [7:0] SLSFP_STROBE_TMO  = 8'hFF;     // no strobe edge: lock lost
   localparam logic [7:0] SLSFP_ZERO8       = 8'h00;

   // ----------------------------------------------------------------
   // synchroniser defaults
   // ----------------------------------------------------------------
   localparam int SLSFP_SYNC_W = 60;

endpackage

// ---- slsfp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser; a change is accepted once stages two and
// three agree, so a single metastable settle never reaches the core
module slsfp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   // pins and clean levels
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] out_r;

   // per-bit stages; the first stage feeds only the second
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               s1_r[g]  <= 1'b0;
               s2_r[g]  <= 1'b0;
               s3_r[g]  <= 1'b0;
               out_r[g] <= 1'b0;
            end else begin
               s1_r[g] <= i_async[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  out_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   assign o_sync = out_r;

endmodule

`default_nettype wire

// ---- slsfp_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module slsfp_top
   import slsfp_pkg::*;
(
   // clock and reset
   input  wire logic                i_core_clk,
   input  wire logic                i_rst,
   // link strobes
   input  wire logic                i_tx_frame_clock_in,
   input  wire logic                i_rx_frame_strobe,
   // controller resets, active low
   input  wire logic                i_link_fsm_reset_a_n,
   input  wire logic                i_link_fsm_reset_b_n,
   // options
   input  wire logic                i_wide_frame_select,
   input  wire logic                i_flag_as_data_select,
   input  wire logic                i_double_frame_select,
   input  wire logic                i_loopback_enable,
   input  wire logic                i_ref_osc_mode,
   input  wire logic [1:0]          i_rate_band_select,
   // transmitter host side
   input  wire logic [SLSFP_DW-1:0] i_tx_data,
   input  wire logic                i_tx_flag,
   input  wire logic                i_tx_data_word_valid_n,
   input  wire logic                i_tx_control_word_valid_n,
   input  wire logic                i_send_enable,
   input  wire logic                i_fill_select,
   // receiver decoder side
   input  wire logic [1:0]          i_rx_kind,
   input  wire logic                i_rx_code_err,
   input  wire logic                i_rx_iflag,
   input  wire logic [SLSFP_DW-1:0] i_rx_data,
   // transmitter outputs
   output logic                     o_tx_locked,
   output logic                     o_ready_for_data,
   output logic                     o_frame_clock_out,
   output logic [1:0]               o_tx_kind,
   output logic [SLSFP_WW-1:0]      o_tx_word,
   output logic                     o_tx_flag,
   // receiver outputs
   output logic [SLSFP_WW-1:0]      o_rx_word,
   output logic                     o_rx_flag,
   output logic                     o_rx_data_word_valid_n,
   output logic                     o_rx_control_word_valid_n,
   output logic                     o_rx_error,
   output logic                     o_link_up,
   output logic                     o_rx_loop_select,
   output logic                     o_rx_ref_select,
   output logic [1:0]               o_rate_band,
   // controller status
   output logic                     o_local_lock_status,
   output logic                     o_peer_ready_status
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [SLSFP_SYNC_W-1:0] pins;
   logic [SLSFP_SYNC_W-1:0] cln;

   assign pins = {i_tx_frame_clock_in, i_rx_frame_strobe, i_link_fsm_reset_a_n,
                  i_link_fsm_reset_b_n, i_wide_frame_select, i_flag_as_data_select,
                  i_double_frame_select, i_loopback_enable, i_ref_osc_mode,
                  i_rate_band_select, i_tx_data, i_tx_flag, i_tx_data_word_valid_n,
                  i_tx_control_word_valid_n, i_send_enable, i_fill_select,
                  i_rx_kind, i_rx_code_err, i_rx_iflag, i_rx_data};

   slsfp_sync #(.W(SLSFP_SYNC_W)) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_async    (pins),
      .o_sync     (cln)
   );

   logic                txs, rxs, rst_a_n, rst_b_n, wide, fsel, dbl, loop, refm;
   logic [1:0]          band, rkind;
   logic [SLSFP_DW-1:0] tdat, rdat;
   logic                tflag, tdav_n, tcav_n, sen, fill, rerr, riflag;

   assign {txs, rxs, rst_a_n, rst_b_n, wide, fsel, dbl, loop, refm, band, tdat, tflag,
           tdav_n, tcav_n, sen, fill, rkind, rerr, riflag, rdat} = cln;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      slsfp_state_t      st;
      logic [7:0]        quiet;
      logic [1:0]        errs;
      logic [1:0]        good;
      logic [1:0]        ff1s;
      logic [1:0]        ff0s;
      logic              stat_pend;
      logic              lock;
      logic              peer;
      logic [SLSFP_WW-1:0] rword;
      logic              rflag;
      logic              rdav_n;
      logic              rcav_n;
      logic              rerr;
      logic              link_up;
      logic              last_dflag;
      logic              ctl_flag;
      logic              txs_d;
      logic              rxs_d;
      logic [7:0]        tcnt;
      logic [7:0]        thalf;
      logic [3:0]        tedges;
      logic              tlocked;
      logic [1:0]        tkind;
      logic [SLSFP_WW-1:0] tword;
      logic              tflag;
      logic              ttoggle;
      logic              ready_for_data;
      logic              fco;
      logic              loop;
      logic              refsel;
      logic [1:0]        band;
   } slsfp_regs_t;

   slsfp_regs_t s_r;
   slsfp_regs_t s_nxt;

   // width mask and flag placement shared by both directions
   function automatic logic [SLSFP_WW-1:0] fmt_word(input logic [SLSFP_DW-1:0] d,
                                                    input logic f, input logic w,
                                                    input logic fs);
      logic [SLSFP_WW-1:0] r;
      r = {1'b0, d} & (w ? SLSFP_MASK_W : SLSFP_MASK_N);
      if (fs) begin
         if (w) r[SLSFP_FLAG_POS_W] = f;
         else   r[SLSFP_FLAG_POS_N] = f;
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic tx_rise, tx_edge, tx_samp, rx_fall, fe_err, ctl_rst;
      logic [1:0] errs_n;
      tx_rise = 1'b0;
      tx_edge = 1'b0;
      tx_samp = 1'b0;
      rx_fall = 1'b0;
      fe_err  = 1'b0;
      ctl_rst = 1'b0;
      errs_n  = 2'h0;
      s_nxt   = s_r;

      s_nxt.txs_d  = txs;
      s_nxt.rxs_d  = rxs;
      s_nxt.loop   = loop;
      s_nxt.band   = band;
      tx_rise      = txs & ~s_r.txs_d;
      tx_edge      = txs ^ s_r.txs_d;
      rx_fall      = ~rxs & s_r.rxs_d;

      // transmitter strobe tracking and lock; a stopped strobe drops lock
      if (tx_edge) begin
         s_nxt.tcnt = SLSFP_ZERO8;
         s_nxt.thalf = {1'b0, s_r.tcnt[7:1]};
      end else if (s_r.tcnt != SLSFP_STROBE_TMO) begin
         s_nxt.tcnt = s_r.tcnt + 8'h01;
      end
      if (s_r.tcnt == SLSFP_STROBE_TMO) begin
         s_nxt.tedges  = 4'h0;
         s_nxt.tlocked = 1'b0;
      end else if (tx_rise) begin
         if (s_r.tedges == SLSFP_TX_LOCK_EDG) s_nxt.tlocked = 1'b1;
         else s_nxt.tedges = s_r.tedges + 4'h1;
      end

      // sample point: rising strobe edge, or mid-way between edges when doubled
      if (dbl) begin
         tx_samp = (s_r.tcnt == s_r.thalf) & ~tx_edge;
         s_nxt.fco = ~tx_edge & (s_r.tcnt >= s_r.thalf);
      end else begin
         tx_samp = tx_rise;
         s_nxt.fco = txs;
      end

      // send enable retimed for the host
      s_nxt.ready_for_data = sen & s_r.tlocked;

      // transmit frame capture
      if (tx_samp) begin
         if (!sen) begin
            s_nxt.tkind = fill ? SLSFP_KIND_FILL1 : SLSFP_KIND_FILL0;
         end else if (!tdav_n) begin
            s_nxt.tkind = SLSFP_KIND_DATA;
         end else if (!tcav_n) begin
            s_nxt.tkind = SLSFP_KIND_CTRL;
         end else begin
            s_nxt.tkind = SLSFP_KIND_FILL0;
         end
         s_nxt.tword = fmt_word(tdat, tflag, wide, fsel);
         if (fsel) begin
            s_nxt.tflag = tflag;
         end else if (sen && !tdav_n) begin
            s_nxt.tflag   = s_r.ttoggle;
            s_nxt.ttoggle = ~s_r.ttoggle;
         end else begin
            s_nxt.tflag = 1'b0;
         end
      end

      // status outputs move one core cycle after the frame outputs
      s_nxt.stat_pend = 1'b0;
      if (s_r.stat_pend) begin
         s_nxt.lock = (s_r.st != SLSFP_ACQ);
         s_nxt.peer = (s_r.st == SLSFP_SEND);
         s_nxt.refsel = refm & (s_r.st == SLSFP_ACQ);
      end

      // receive frame on the falling recovered strobe
      if (rx_fall) begin
         fe_err = rerr;
         if (!fsel && rkind == SLSFP_KIND_DATA && riflag == s_r.last_dflag) begin
            fe_err = 1'b1;
         end
         s_nxt.rword  = fmt_word(rdat, riflag, wide, fsel);
         s_nxt.rdav_n = (rkind != SLSFP_KIND_DATA);
         s_nxt.rcav_n = (rkind != SLSFP_KIND_CTRL);
         s_nxt.rerr   = fe_err;
         if (rkind == SLSFP_KIND_DATA) begin
            s_nxt.rflag      = riflag;
            s_nxt.last_dflag = riflag;
         end else if (rkind == SLSFP_KIND_CTRL && !fsel) begin
            s_nxt.rflag    = s_r.ctl_flag;
            s_nxt.ctl_flag = ~s_r.ctl_flag;
         end else begin
            s_nxt.rflag = 1'b0;
         end

         // debounce counters
         errs_n = fe_err ? ((s_r.errs == SLSFP_ERR_LIMIT) ? s_r.errs : s_r.errs + 2'h1)
                         : 2'h0;
         s_nxt.errs = errs_n;
         s_nxt.good = fe_err ? 2'h0 : ((s_r.good == SLSFP_AGREE) ? s_r.good
                                                                 : s_r.good + 2'h1);
         s_nxt.ff1s = (!fe_err && rkind == SLSFP_KIND_FILL1) ?
                      ((s_r.ff1s == SLSFP_AGREE) ? s_r.ff1s : s_r.ff1s + 2'h1) : 2'h0;
         s_nxt.ff0s = (!fe_err && rkind == SLSFP_KIND_FILL0) ?
                      ((s_r.ff0s == SLSFP_AGREE) ? s_r.ff0s : s_r.ff0s + 2'h1) : 2'h0;

         if (errs_n == SLSFP_ERR_LIMIT) begin
            s_nxt.st    = SLSFP_ACQ;
            s_nxt.quiet = SLSFP_ZERO8;
         end else begin
            if (!fe_err && s_r.quiet != SLSFP_QUIET) begin
               s_nxt.quiet = s_r.quiet + 8'h01;
            end
            case (s_r.st)
               SLSFP_ACQ: begin
                  if (s_r.quiet == SLSFP_QUIET && s_nxt.good == SLSFP_AGREE) begin
                     s_nxt.st = SLSFP_WAIT;
                  end
               end
               SLSFP_WAIT: begin
                  if (s_nxt.ff1s == SLSFP_AGREE) s_nxt.st = SLSFP_SEND;
               end
               SLSFP_SEND: begin
                  if (s_nxt.ff0s == SLSFP_AGREE) s_nxt.st = SLSFP_WAIT;
               end
               default: s_nxt.st = SLSFP_ACQ;
            endcase
         end
         s_nxt.link_up   = (s_nxt.st == SLSFP_SEND);
         s_nxt.stat_pend = 1'b1;
      end

      // either controller reset, or an unlocked transmitter, forces acquisition
      ctl_rst = ~rst_a_n | ~rst_b_n | ~s_r.tlocked;
      if (ctl_rst) begin
         s_nxt.st        = SLSFP_ACQ;
         s_nxt.quiet     = SLSFP_ZERO8;
         s_nxt.errs      = 2'h0;
         s_nxt.good      = 2'h0;
         s_nxt.ff1s      = 2'h0;
         s_nxt.ff0s      = 2'h0;
         s_nxt.lock      = 1'b0;
         s_nxt.peer      = 1'b0;
         s_nxt.refsel    = refm;
         s_nxt.link_up   = 1'b0;
         s_nxt.stat_pend = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r <= '0;
         s_r.st     <= SLSFP_ACQ;
         s_r.rdav_n <= 1'b1;
         s_r.rcav_n <= 1'b1;
         s_r.last_dflag <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs, straight from the state register
   // ----------------------------------------------------------------
   assign o_tx_locked               = s_r.tlocked;
   assign o_ready_for_data          = s_r.ready_for_data;
   assign o_frame_clock_out         = s_r.fco;
   assign o_tx_kind                 = s_r.tkind;
   assign o_tx_word                 = s_r.tword;
   assign o_tx_flag                 = s_r.tflag;
   assign o_rx_word                 = s_r.rword;
   assign o_rx_flag                 = s_r.rflag;
   assign o_rx_data_word_valid_n    = s_r.rdav_n;
   assign o_rx_control_word_valid_n = s_r.rcav_n;
   assign o_rx_error                = s_r.rerr;
   assign o_link_up                 = s_r.link_up;
   assign o_rx_loop_select          = s_r.loop;
   assign o_rx_ref_select           = s_r.refsel;
   assign o_rate_band               = s_r.band;
   assign o_local_lock_status       = s_r.lock;
   assign o_peer_ready_status       = s_r.peer;

endmodule

`default_nettype wire

// ---- slsfp_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// port checker for the link start-up block
// --------------------------------------------------------------
module slsfp_top_monitor (
   // clock, reset and watched inputs
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_rx_frame_strobe,
   input wire logic i_link_fsm_reset_a_n,
   input wire logic i_link_fsm_reset_b_n,
   input wire logic i_send_enable,
   // watched outputs
   input wire logic o_tx_locked,
   input wire logic o_ready_for_data,
   input wire logic o_rx_flag,
   input wire logic o_rx_data_word_valid_n,
   input wire logic o_rx_control_word_valid_n,
   input wire logic o_rx_error,
   input wire logic o_rx_ref_select,
   input wire logic o_local_lock_status,
   input wire logic o_peer_ready_status
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic       stb_r, rsts, idle, fall;
   logic [1:0] erun_r;
   logic [7:0] quiet_r;
   assign rsts = !i_link_fsm_reset_a_n || !i_link_fsm_reset_b_n;
   assign idle = !o_local_lock_status && !o_peer_ready_status;
   assign fall = stb_r && !i_rx_frame_strobe;
   // error runs and clean frames, seen one frame late
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         stb_r   <= 1'b0;
         erun_r  <= 2'h0;
         quiet_r <= 8'h00;
      end else begin
         stb_r <= i_rx_frame_strobe;
         if (rsts || !o_tx_locked) begin
            erun_r  <= 2'h0;
            quiet_r <= 8'h00;
         end else if (fall && o_rx_error) begin
            erun_r  <= (erun_r == 2'h0) ? 2'h1 : 2'h2;
            quiet_r <= (erun_r == 2'h0) ? quiet_r : 8'h00;
         end else if (fall) begin
            erun_r  <= 2'h0;
            quiet_r <= (quiet_r == 8'hFF) ? quiet_r : quiet_r + 8'h01;
         end
      end
   end
   property p_ctl_rst; rsts [*8] |-> idle; endproperty
   a_ctl_rst: assert property (p_ctl_rst) else $error("status high in reset");
   property p_unlock; (!o_tx_locked) [*8] |-> idle; endproperty
   a_unlock: assert property (p_unlock) else $error("status high unlocked");
   property p_rdy; (o_tx_locked && $stable(i_send_enable)) [*8]
      |-> o_ready_for_data == i_send_enable; endproperty
   a_rdy: assert property (p_rdy) else $error("ready does not follow send");
   property p_peer; o_peer_ready_status |-> o_local_lock_status; endproperty
   a_peer: assert property (p_peer) else $error("peer ready without lock");
   property p_fill; o_rx_data_word_valid_n && o_rx_control_word_valid_n |-> !o_rx_flag; endproperty
   a_fill: assert property (p_fill) else $error("fill frame with flag");
   property p_ref; o_local_lock_status |-> !o_rx_ref_select; endproperty
   a_ref: assert property (p_ref) else $error("reference kept after lock");
   property p_drop; erun_r == 2'h2 |-> !o_local_lock_status; endproperty
   a_drop: assert property (p_drop) else $error("lock kept after two errors");
   property p_quiet; $rose(o_local_lock_status) |-> quiet_r >= 8'h7E; endproperty
   a_quiet: assert property (p_quiet) else $error("lock before clean frames");
   cover property ($rose(o_local_lock_status));
   cover property ($rose(o_peer_ready_status));
   cover property (erun_r == 2'h2);
endmodule
`default_nettype wire

// ---- slsfp_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// far-end peer: recovered frame strobe and decoded frame fields
// --------------------------------------------------------------
module slsfp_peer_model
   import slsfp_pkg::*;
(
   // commands from the bench
   input  wire logic       i_run,
   input  wire logic [1:0] i_kind,
   input  wire logic       i_err,
   input  wire logic       i_rep,
   // frame lines
   output logic            o_stb,
   output logic [1:0]      o_kind,
   output logic            o_err,
   output logic            o_iflag,
   output logic [19:0]     o_data,
   output int              o_nfr
);
   // strobe stands still between bursts; fields load half a frame before the fall
   initial begin
      {o_stb, o_kind, o_err, o_data, o_nfr} = '0;
      o_iflag = 1'b1;
      #1.3;
      forever begin
         #62.5;
         if (i_run) begin
            o_stb = 1'b1;
            o_kind = i_kind;
            o_err = i_err;
            o_iflag = (i_kind == SLSFP_KIND_DATA && !i_rep) ? ~o_iflag : o_iflag;
            o_data = o_data + 20'h1_1111;
            #62.5;
            o_stb = 1'b0;
            o_nfr = o_nfr + 1;
         end else begin
            o_data = ~o_data; // idle lines wander, never hold a stale word
         end
      end
   end
endmodule
`default_nettype wire

// ---- test_slsfp_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// self-checking bench for the link start-up block
// --------------------------------------------------------------
module test_slsfp_top;
   import slsfp_pkg::*;
   typedef struct packed {logic [5:0] ctl; logic [1:0] kind; logic [20:0] word;} slsfp_row_t;
   // ctl: send, fill kind, wide, flag as data, data valid_n, control valid_n
   localparam slsfp_row_t ROWS [7] = '{
      '{6'h01, SLSFP_KIND_FILL0, 21'h00_0000},
      '{6'h11, SLSFP_KIND_FILL1, 21'h00_0000},
      '{6'h21, SLSFP_KIND_DATA,  21'h00_5C3F},
      '{6'h29, SLSFP_KIND_DATA,  21'h0A_5C3F},
      '{6'h25, SLSFP_KIND_DATA,  21'h01_5C3F},
      '{6'h2D, SLSFP_KIND_DATA,  21'h1A_5C3F},
      '{6'h22, SLSFP_KIND_CTRL,  21'h00_0000}};
   localparam logic [20:0] ONE = 21'h00_0001, ZERO = 21'h00_0000;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_tx_frame_clock_in = 1'b0, i_rx_frame_strobe;
   logic i_link_fsm_reset_a_n = 1'b1, i_link_fsm_reset_b_n = 1'b1, i_double_frame_select = 1'b0;
   logic i_wide_frame_select = 1'b0, i_flag_as_data_select = 1'b0, i_loopback_enable = 1'b1;
   logic i_ref_osc_mode = 1'b0, i_tx_flag = 1'b1, i_tx_data_word_valid_n = 1'b1;
   logic i_tx_control_word_valid_n = 1'b1, i_send_enable, i_fill_select, i_rx_code_err;
   logic i_rx_iflag, se = 1'b0, fs = 1'b0, sys = 1'b0, run = 1'b0, err = 1'b0, rep = 1'b0;
   logic [1:0] i_rate_band_select = 2'h2, kind = SLSFP_KIND_FILL0, i_rx_kind;
   logic [19:0] i_tx_data = 20'hA_5C3F, i_rx_data;
   logic o_tx_locked, o_ready_for_data, o_frame_clock_out, o_tx_flag, o_rx_flag, trun = 1'b1;
   logic o_rx_data_word_valid_n, o_rx_control_word_valid_n, o_rx_error, o_link_up, f;
   logic o_rx_loop_select, o_rx_ref_select, o_local_lock_status, o_peer_ready_status;
   logic [1:0] o_tx_kind, o_rate_band;
   logic [20:0] o_tx_word, o_rx_word;
   int n_mismatch = 0, checks_done = 0, nfr;
   // system wiring of the status outputs back to the transmitter controls
   assign i_send_enable = sys ? o_peer_ready_status : se;
   assign i_fill_select = sys ? o_local_lock_status : fs;
   slsfp_top dut (.i_core_clk, .i_rst, .i_tx_frame_clock_in, .i_rx_frame_strobe,
      .i_link_fsm_reset_a_n, .i_link_fsm_reset_b_n, .i_wide_frame_select, .i_flag_as_data_select,
      .i_double_frame_select, .i_loopback_enable, .i_ref_osc_mode, .i_rate_band_select,
      .i_tx_data, .i_tx_flag, .i_tx_data_word_valid_n, .i_tx_control_word_valid_n,
      .i_send_enable, .i_fill_select, .i_rx_kind, .i_rx_code_err, .i_rx_iflag, .i_rx_data,
      .o_tx_locked, .o_ready_for_data, .o_frame_clock_out, .o_tx_kind, .o_tx_word, .o_tx_flag,
      .o_rx_word, .o_rx_flag, .o_rx_data_word_valid_n, .o_rx_control_word_valid_n, .o_rx_error,
      .o_link_up, .o_rx_loop_select, .o_rx_ref_select, .o_rate_band, .o_local_lock_status,
      .o_peer_ready_status);
   slsfp_peer_model peer (.i_run(run), .i_kind(kind), .i_err(err), .i_rep(rep),
      .o_stb(i_rx_frame_strobe), .o_kind(i_rx_kind), .o_err(i_rx_code_err),
      .o_iflag(i_rx_iflag), .o_data(i_rx_data), .o_nfr(nfr));
   // core clock, and a host strobe offset so its edges never meet the core's
   always #2.5 i_core_clk = ~i_core_clk;
   initial #0.7 forever #62.5 if (trun) i_tx_frame_clock_in = ~i_tx_frame_clock_in;
   task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // whole host strobe periods, so two waits land at the same phase
   task automatic txw(input int n);
      repeat (n * 25) @(negedge i_core_clk);
   endtask
   // n received frames, bounded, then room for frame and status outputs
   task automatic frames(input int n);
      int t;
      t = nfr + n;
      for (int i = 0; i < n * 40 + 40 && nfr < t; i++) @(negedge i_core_clk);
      if (nfr >= t) repeat (8) @(negedge i_core_clk);
      else begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   task automatic fco(input logic [20:0] exp);
      logic [20:0] c;
      logic p;
      c = ZERO;
      p = o_frame_clock_out;
      repeat (250) begin
         @(negedge i_core_clk);
         c = c + 21'(o_frame_clock_out && !p);
         p = o_frame_clock_out;
      end
      chk("frame_clock_rises", exp, c);
   endtask
   initial begin
      repeat (10) @(negedge i_core_clk);
      i_rst = 1'b0;
      txw(8);
      chk("tx_locked", ONE, 21'(o_tx_locked));
      chk("loop_select", ONE, 21'(o_rx_loop_select));
      chk("rate_band", 21'(2'h2), 21'(o_rate_band));
      foreach (ROWS[r]) begin
         {se, fs, i_wide_frame_select, i_flag_as_data_select, i_tx_data_word_valid_n,
          i_tx_control_word_valid_n} = ROWS[r].ctl;
         txw(3);
         chk("tx_kind", 21'(ROWS[r].kind), 21'(o_tx_kind));
         chk("ready", 21'(ROWS[r].ctl[5]), 21'(o_ready_for_data));
         if (ROWS[r].kind == SLSFP_KIND_DATA) chk("tx_word", ROWS[r].word, o_tx_word);
      end
      $display("host frame table done");
      {se, i_flag_as_data_select, i_tx_data_word_valid_n, i_tx_control_word_valid_n} = 4'h9;
      txw(3);
      f = o_tx_flag;
      txw(1);
      chk("tx_flag_toggle", 21'(!f), 21'(o_tx_flag));
      fco(21'h00_000A);
      i_double_frame_select = 1'b1;
      txw(1);
      fco(21'h00_0014);
      i_double_frame_select = 1'b0;
      $display("flag and strobe tests done");
      {sys, run, i_ref_osc_mode} = 3'h7;
      frames(2);
      chk("tx_kind_acq", 21'(SLSFP_KIND_FILL0), 21'(o_tx_kind));
      chk("ref_select", ONE, 21'(o_rx_ref_select));
      frames(118);
      chk("lock_early", ZERO, 21'(o_local_lock_status));
      frames(12);
      chk("lock", ONE, 21'(o_local_lock_status));
      chk("ref_select_off", ZERO, 21'(o_rx_ref_select));
      chk("fill_vld", 21'h3, 21'({o_rx_data_word_valid_n, o_rx_control_word_valid_n}));
      frames(1);
      chk("tx_kind_fill1", 21'(SLSFP_KIND_FILL1), 21'(o_tx_kind));
      kind = SLSFP_KIND_FILL1;
      frames(1);
      kind = SLSFP_KIND_FILL0;
      frames(3);
      chk("peer_one_frame", ZERO, 21'(o_peer_ready_status));
      kind = SLSFP_KIND_FILL1;
      frames(3);
      chk("peer_ready", ONE, 21'(o_peer_ready_status));
      kind = SLSFP_KIND_DATA;
      frames(3);
      chk("ready_link", ONE, 21'(o_ready_for_data));
      chk("rx_data_valid", ZERO, 21'(o_rx_data_word_valid_n));
      chk("link_up", ONE, 21'(o_link_up));
      chk("rx_word_hi", ZERO, 21'(o_rx_word[20:16]));
      chk("rx_error_clean", ZERO, 21'(o_rx_error));
      rep = 1'b1;
      frames(1);
      rep = 1'b0;
      chk("rx_error_repeat", ONE, 21'(o_rx_error));
      frames(2);
      chk("peer_single_error", ONE, 21'(o_peer_ready_status));
      kind = SLSFP_KIND_FILL0;
      i_link_fsm_reset_b_n = 1'b0;
      repeat (10) @(negedge i_core_clk);
      chk("ctl_reset", ZERO, 21'({o_local_lock_status, o_peer_ready_status}));
      i_link_fsm_reset_b_n = 1'b1;
      frames(132);
      chk("relock", ONE, 21'(o_local_lock_status));
      err = 1'b1;
      frames(1);
      chk("lock_one_error", ONE, 21'(o_local_lock_status));
      frames(1);
      err = 1'b0;
      chk("lock_two_errors", ZERO, 21'(o_local_lock_status));
      chk("ref_select_back", ONE, 21'(o_rx_ref_select));
      $display("handshake tests done");
      trun = 1'b0;
      repeat (300) @(negedge i_core_clk);
      chk("tx_lock_lost", ZERO, 21'(o_tx_locked));
      $display("strobe loss test done");
      end_of_test();
   end
endmodule
bind slsfp_top slsfp_top_monitor mon (.*);
`default_nettype wire
